/* File: rtl/eepc_pkg.sv */
package eepc_pkg;

    // Register and nonvolatile locations in the processor address space
    localparam logic [15:0] ADDR_CONTROL     = 16'h0010;
    localparam logic [15:0] ADDR_CONFIG      = 16'h0011;
    localparam logic [15:0] ADDR_DIV_HIGH    = 16'h0012;
    localparam logic [15:0] ADDR_DIV_LOW     = 16'h0013;
    localparam logic [15:0] ADDR_NV_PROT     = 16'h0020;
    localparam logic [15:0] ADDR_NV_DIV_HIGH = 16'h0021;
    localparam logic [15:0] ADDR_NV_DIV_LOW  = 16'h0022;
    localparam logic [15:0] ARRAY_FIRST      = 16'h0800;
    localparam logic [15:0] ARRAY_LAST       = 16'h09FF;
    localparam logic [11:0] SECURE_PAGE      = 12'h08F;
    localparam int          BLOCK_LSB        = 7;

    // array_control fields
    localparam int          CTL_POWER_DOWN   = 6;
    localparam int          CTL_MODE_HI      = 5;
    localparam int          CTL_MODE_LO      = 4;
    localparam int          CTL_LATCH        = 3;
    localparam int          CTL_AUTO         = 2;
    localparam int          CTL_HV           = 0;
    localparam logic [7:0]  CTL_RW_MASK      = 8'hFD;
    localparam logic [7:0]  CTL_RESET        = 8'h00;

    // array_configuration and divider fields
    localparam int          CFG_SECURITY_ARM = 4;
    localparam int          DIVH_SECD        = 7;
    localparam logic [7:0]  DIVH_MASK        = 8'h87;
    localparam int          DIVISOR_W        = 11;

    localparam logic [7:0]  RDATA_IDLE       = 8'h00;
    localparam logic [7:0]  RDATA_OFF        = 8'hFF;

    // Timebase period in microseconds; the divisor itself comes from software
    localparam int          TIMEBASE_US      = 35;

    // Auto-terminate lengths in timebase ticks, each short of its mode's time
    localparam logic [7:0]  TICKS_PGM        = 8'h40;
    localparam logic [7:0]  TICKS_BYTE       = 8'h60;
    localparam logic [7:0]  TICKS_BLOCK      = 8'h80;
    localparam logic [7:0]  TICKS_BULK       = 8'hA0;

    typedef enum logic [1:0] {
        MODE_BYTE_PGM   = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK      = 2'b10,
        MODE_BULK       = 2'b11
    } eepc_mode_e;

endpackage

/* File: rtl/eepc_ctrl.sv */
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Next array write picks erase target
// - Auto timer clears high voltage enable
// - Latch only writes to valid locations
// - Control writes wait for latched write
// - Latest valid write replaces captured values
// - Latched read returns captured data, takes address
// - Refuse high voltage without latch, valid address
// - Latch stays set while high voltage
// - Auto cycle shorter than specified time
// - Power down disables array accesses
// - Mode encoding; protected block suppresses operation
// - High voltage drives pump when allowed
// - Reset loads configuration from nonvolatile copy
// - Security once armed stays armed
// - Four block protect bits guard blocks
// - Security locks range 08F0-08FF, block, bulk
// - Protection byte programmed like array byte
// - Eleven bit divisor sets timebase
// - Reset loads divider from nonvolatile copies
// - Divisor writable only unlatched and unsecured
module eepc_ctrl
    import eepc_pkg::*;
#(
    parameter logic [7:0] PGM_TICKS   = TICKS_PGM,
    parameter logic [7:0] BYTE_TICKS  = TICKS_BYTE,
    parameter logic [7:0] BLOCK_TICKS = TICKS_BLOCK,
    parameter logic [7:0] BULK_TICKS  = TICKS_BULK
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [7:0]  ARR_RDATA,
    input  wire logic [7:0]  NV_PROTECTION,
    input  wire logic [7:0]  NV_DIV_HIGH,
    input  wire logic [7:0]  NV_DIV_LOW,
    input  wire logic        REF_CLK,
    output logic      [15:0] ARR_ADDR,
    output logic      [7:0]  ARR_DATA,
    output logic      [1:0]  ARR_MODE,
    output logic             ARR_HV,
    output logic             ARR_POWER_DOWN
);

    typedef struct packed {
        logic [7:0]           ctrl;
        logic [7:0]           config_b;
        logic [7:0]           div_high;
        logic [7:0]           div_low;
        logic [15:0]          cap_addr;
        logic [7:0]           cap_data;
        logic                 cap_valid;
        logic [7:0]           rdata;
        logic [2:0]           ref_sync;
        logic [DIVISOR_W-1:0] div_cnt;
        logic                 tick;
        logic [7:0]           auto_cnt;
        logic                 hv_out;
    } eepc_state_s;

    eepc_state_s r;
    eepc_state_s n;

    function automatic logic is_array(input logic [15:0] a);
        is_array = (a >= ARRAY_FIRST) && (a <= ARRAY_LAST);
    endfunction

    function automatic logic is_nvr(input logic [15:0] a);
        is_nvr = (a == ADDR_NV_PROT) || (a == ADDR_NV_DIV_HIGH) || (a == ADDR_NV_DIV_LOW);
    endfunction

    function automatic logic is_target(input logic [15:0] a);
        is_target = is_array(a) || is_nvr(a);
    endfunction

    // Whether the pump may act on the captured location in this mode
    function automatic logic op_allowed(input logic [15:0] a,
                                        input logic [1:0]  mode,
                                        input logic [7:0]  cfg,
                                        input logic [7:0]  divh);
        logic secured;
        logic ok;
        secured = ~cfg[CFG_SECURITY_ARM];
        ok      = 1'b0;
        if (is_array(a)) begin
            ok = 1'b1;
            if (cfg[a[BLOCK_LSB+1:BLOCK_LSB]]) begin
                ok = 1'b0;
            end
            if ((mode == MODE_BULK) && (cfg[3:0] != 4'h0)) begin
                ok = 1'b0;
            end
            // secured range 08F0-08FF and multi-byte erase
            if (secured && ((a[15:4] == SECURE_PAGE) || mode[1])) begin
                ok = 1'b0;
            end
        end else if (a == ADDR_NV_PROT) begin
            // armed security locks its own byte
            ok = ~secured && ~mode[1];
        end else if (is_nvr(a)) begin
            ok = divh[DIVH_SECD] && ~mode[1];
        end
        op_allowed = ok;
    endfunction

    function automatic logic [7:0] mode_ticks(input logic [1:0] mode);
        case (mode)
            MODE_BYTE_PGM:   mode_ticks = PGM_TICKS;
            MODE_BYTE_ERASE: mode_ticks = BYTE_TICKS;
            MODE_BLOCK:      mode_ticks = BLOCK_TICKS;
            MODE_BULK:       mode_ticks = BULK_TICKS;
            default:         mode_ticks = PGM_TICKS;
        endcase
    endfunction

    logic                 wr_ctrl;
    logic                 rd_target;
    logic                 wr_target;
    logic                 latched;
    logic                 hv_now;
    logic                 auto_done;
    logic [DIVISOR_W-1:0] divisor;
    logic [7:0]           ctl_w;

    assign latched   = r.ctrl[CTL_LATCH];
    assign hv_now    = r.ctrl[CTL_HV];
    // power down shuts the array off the bus
    assign rd_target = RD && is_target(ADDR) && !r.ctrl[CTL_POWER_DOWN];
    assign wr_target = WR && is_target(ADDR) && !r.ctrl[CTL_POWER_DOWN];
    assign wr_ctrl   = WR && (ADDR == ADDR_CONTROL);
    assign divisor   = {r.div_high[2:0], r.div_low};
    assign ctl_w     = WDATA & CTL_RW_MASK;
    // counts stay short of the specified time
    assign auto_done = hv_now && r.ctrl[CTL_AUTO] && r.tick &&
                       (r.auto_cnt >= (mode_ticks(r.ctrl[CTL_MODE_HI:CTL_MODE_LO]) - 8'h01));

    always_comb begin
        n       = r;
        n.rdata = RDATA_IDLE;
        n.tick  = 1'b0;

        // First stage feeds only the second
        n.ref_sync = {r.ref_sync[1:0], REF_CLK};
        // divide reference edges by the divisor
        if (r.ref_sync[1] && !r.ref_sync[2]) begin
            if (r.div_cnt >= (divisor - 11'h001)) begin
                n.div_cnt = '0;
                n.tick    = 1'b1;
            end else begin
                n.div_cnt = r.div_cnt + 11'h001;
            end
        end

        if (wr_target && latched) begin
            n.cap_addr  = ADDR;
            n.cap_data  = WDATA;
            n.cap_valid = 1'b1;
        end

        if (wr_ctrl) begin
            // control locked until a write is latched
            if (!latched || r.cap_valid) begin
                n.ctrl = ctl_w;
                // refuse pump without latch or target
                // A write that drops the latch may never start the pump
                if (!(latched && r.cap_valid && ctl_w[CTL_LATCH])) begin
                    n.ctrl[CTL_HV] = 1'b0;
                end
                // clearing both only drops the pump
                if (hv_now && !ctl_w[CTL_LATCH]) begin
                    n.ctrl[CTL_LATCH] = 1'b1;
                    n.ctrl[CTL_HV]    = 1'b0;
                end
            end
        end

        if (auto_done) begin
            n.ctrl[CTL_HV] = 1'b0;
        end
        if (!n.ctrl[CTL_HV]) begin
            n.auto_cnt = 8'h00;
        end else if (r.tick && r.ctrl[CTL_AUTO]) begin
            n.auto_cnt = r.auto_cnt + 8'h01;
        end
        if (!n.ctrl[CTL_LATCH]) begin
            n.cap_valid = 1'b0;
        end

        if (WR && !latched && r.div_high[DIVH_SECD]) begin
            if (ADDR == ADDR_DIV_HIGH) begin
                n.div_high = WDATA & DIVH_MASK;
            end
            if (ADDR == ADDR_DIV_LOW) begin
                n.div_low = WDATA;
            end
        end

        if (RD) begin
            case (ADDR)
                ADDR_CONTROL:  n.rdata = r.ctrl;
                ADDR_CONFIG:   n.rdata = r.config_b;
                ADDR_DIV_HIGH: n.rdata = r.div_high;
                ADDR_DIV_LOW:  n.rdata = r.div_low;
                default:       n.rdata = RDATA_IDLE;
            endcase
            if (is_target(ADDR) && r.ctrl[CTL_POWER_DOWN]) begin
                n.rdata = RDATA_OFF;
            end
        end
        if (rd_target) begin
            if (latched) begin
                n.rdata    = r.cap_data;
                n.cap_addr = ADDR;
            end else begin
                n.rdata = ARR_RDATA;
                // Reading the protection byte refreshes protection until security is armed
                if (ADDR == ADDR_NV_PROT && r.config_b[CFG_SECURITY_ARM]) begin
                    n.config_b = ARR_RDATA;
                end
            end
        end

        // pump only on a permitted latched target
        n.hv_out = n.ctrl[CTL_HV] && n.cap_valid && !n.ctrl[CTL_POWER_DOWN] &&
                   op_allowed(n.cap_addr, n.ctrl[CTL_MODE_HI:CTL_MODE_LO], n.config_b, n.div_high);
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            r          <= '0;
            r.ctrl     <= CTL_RESET;
            r.config_b <= NV_PROTECTION;
            r.div_high <= NV_DIV_HIGH & DIVH_MASK;
            r.div_low  <= NV_DIV_LOW;
        end else begin
            r <= n;
        end
    end

    assign RDATA          = r.rdata;
    assign ARR_ADDR       = r.cap_addr;
    assign ARR_DATA       = r.cap_data;
    assign ARR_MODE       = r.ctrl[CTL_MODE_HI:CTL_MODE_LO];
    assign ARR_HV         = r.hv_out;
    assign ARR_POWER_DOWN = r.ctrl[CTL_POWER_DOWN];

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_pump_on;
        hv_now && latched;
    endsequence

    sequence s_clear_both;
        wr_ctrl && !WDATA[CTL_LATCH] && !WDATA[CTL_HV];
    endsequence

    a_hv_needs_latch: assert property (hv_now |-> latched && r.cap_valid)
        else $error("high voltage set without latched target");

    a_hv_refused: assert property (wr_ctrl && !latched |=> !hv_now)
        else $error("high voltage set while latch was clear");

    a_latch_kept: assert property (s_pump_on ##0 s_clear_both |=> latched && !hv_now)
        else $error("latch cleared together with high voltage");

    a_capture_new: assert property (wr_target && latched |=> r.cap_addr == $past(ADDR)
                                    && r.cap_data == $past(WDATA))
        else $error("valid write not captured");

    a_no_capture: assert property (WR && !is_target(ADDR) && !rd_target && !wr_ctrl
                                   |=> $stable(r.cap_data))
        else $error("invalid write changed captured data");

    a_read_latched: assert property (rd_target && latched && !WR
                                     |=> RDATA == $past(r.cap_data) && ARR_ADDR == $past(ADDR))
        else $error("latched read wrong data or address");

    a_ctrl_locked: assert property (wr_ctrl && latched && !r.cap_valid |=> $stable(r.ctrl[7:1]))
        else $error("control written before a latched write");

    a_div_locked: assert property (WR && latched && ADDR == ADDR_DIV_LOW |=> $stable(r.div_low))
        else $error("divisor written while latched");

    a_auto_end: assert property (auto_done && !wr_ctrl |=> !hv_now ##1 !ARR_HV)
        else $error("auto timer did not end the cycle");

    a_tick_single: assert property (r.tick |=> !r.tick)
        else $error("timebase tick longer than one cycle");

    a_secure_top: assert property (ARR_HV && !r.config_b[CFG_SECURITY_ARM]
                                   |-> ARR_ADDR[15:4] != SECURE_PAGE && !ARR_MODE[1])
        else $error("pump on secured range or multi-byte erase");

    a_block_guard: assert property (ARR_HV && is_array(ARR_ADDR)
                                    |-> !r.config_b[ARR_ADDR[BLOCK_LSB+1:BLOCK_LSB]])
        else $error("pump on protected block");

    // Pump start: latched target present, latch kept, no timer end in the same cycle
    sequence s_hv_request;
        wr_ctrl && WDATA[CTL_HV] && WDATA[CTL_LATCH] && latched && r.cap_valid && !auto_done;
    endsequence

    a_hv_starts: assert property (s_hv_request |=> hv_now)
        else $error("permitted pump request not accepted");

    a_latch_drop_hv: assert property (wr_ctrl && !WDATA[CTL_LATCH] |=> !hv_now)
        else $error("pump left on by a write dropping the latch");

    a_pd_read: assert property (RD && is_target(ADDR) && r.ctrl[CTL_POWER_DOWN]
                                |=> RDATA == RDATA_OFF)
        else $error("powered down array read not blocked");

    a_pd_no_hv: assert property (ARR_POWER_DOWN |-> !ARR_HV)
        else $error("pump on while array powered down");

    a_pd_no_capture: assert property (WR && is_target(ADDR) && r.ctrl[CTL_POWER_DOWN]
                                      |=> $stable(r.cap_addr))
        else $error("powered down write was captured");

    a_arm_kept: assert property (!r.config_b[CFG_SECURITY_ARM] |=> !r.config_b[CFG_SECURITY_ARM])
        else $error("armed security was released");

    a_div_secured: assert property (WR && !r.div_high[DIVH_SECD] && ADDR == ADDR_DIV_HIGH
                                    |=> $stable(r.div_high))
        else $error("divider written while secured");

    a_bulk_guard: assert property (ARR_HV && ARR_MODE == MODE_BULK |-> r.config_b[3:0] == 4'h0)
        else $error("bulk erase with a protected block");

    // Counter must restart for every cycle, or a later cycle ends early
    a_cnt_idle: assert property (!hv_now |-> r.auto_cnt == 8'h00)
        else $error("auto counter not cleared while idle");

    a_unlatched_free: assert property (!latched |-> !r.cap_valid)
        else $error("capture kept after latch cleared");

    a_rdata_idle: assert property (!RD |=> RDATA == RDATA_IDLE)
        else $error("read data not idle after no read");

endmodule

/* File: test/eepc_array_model.sv */
`timescale 1ns/1ps

module eepc_array_model
    import eepc_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic [15:0] ADDR,
    input  wire logic [15:0] ARR_ADDR,
    input  wire logic [7:0]  ARR_DATA,
    input  wire logic [1:0]  ARR_MODE,
    input  wire logic        ARR_HV,
    output logic      [7:0]  ARR_RDATA
);
    logic [7:0] mem [0:511];
    logic       hv_d;
    logic [7:0] junk;

    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
        hv_d = 1'b0;
        junk = 8'h5A;
    end

    // Off-array reads see a toggling pattern so stale data never passes
    always_comb begin
        if (ADDR >= ARRAY_FIRST && ADDR <= ARRAY_LAST) ARR_RDATA = mem[ADDR[8:0]];
        else ARR_RDATA = junk;
    end

    always @(posedge MCLK) begin
        hv_d <= ARR_HV;
        junk <= ~junk;
        if (ARR_HV && !hv_d && ARR_ADDR >= ARRAY_FIRST && ARR_ADDR <= ARRAY_LAST) begin
            case (ARR_MODE)
                MODE_BYTE_PGM:   mem[ARR_ADDR[8:0]] <= mem[ARR_ADDR[8:0]] & ARR_DATA;
                MODE_BYTE_ERASE: mem[ARR_ADDR[8:0]] <= 8'hFF;
                MODE_BLOCK:      for (int i = 0; i < 128; i++) mem[{ARR_ADDR[8:7], i[6:0]}] <= 8'hFF;
                default:         for (int i = 0; i < 512; i++) mem[i] <= 8'hFF;
            endcase
        end
    end
endmodule

/* File: test/eeprom_program_erase_ctrl_test.sv */
`timescale 1ns/1ps

module eeprom_program_erase_ctrl_test
    import eepc_pkg::*;
;
    logic        mclk, rst_n, wr, rd, ref_clk, arr_hv, arr_pd;
    logic [15:0] addr, arr_addr;
    logic [7:0]  wdata, rdata, arr_rdata, nv_prot, nv_divh, nv_divl, arr_data, got;
    logic [1:0]  arr_mode;
    int          miscompares, samples_checked, cycles;

    eepc_ctrl #(.PGM_TICKS(8'h03), .BYTE_TICKS(8'h03), .BLOCK_TICKS(8'h04), .BULK_TICKS(8'h04)) dut_u (
        .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .ARR_RDATA(arr_rdata), .NV_PROTECTION(nv_prot), .NV_DIV_HIGH(nv_divh), .NV_DIV_LOW(nv_divl),
        .REF_CLK(ref_clk), .ARR_ADDR(arr_addr), .ARR_DATA(arr_data), .ARR_MODE(arr_mode),
        .ARR_HV(arr_hv), .ARR_POWER_DOWN(arr_pd));

    eepc_array_model model_u (.MCLK(mclk), .ADDR(addr), .ARR_ADDR(arr_addr), .ARR_DATA(arr_data),
        .ARR_MODE(arr_mode), .ARR_HV(arr_hv), .ARR_RDATA(arr_rdata));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Reference clock unrelated to the bus clock
    initial begin
        ref_clk = 1'b0;
        forever #13 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic do_reset(input logic [7:0] p, input logic [7:0] h, input logic [7:0] l);
        nv_prot <= p;
        nv_divh <= h;
        nv_divl <= l;
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic test_reset_regs();
        rd8(ADDR_CONTROL, got); chk(got, 16'h00);
        rd8(ADDR_CONFIG, got);  chk(got, 16'hF2);
        rd8(ADDR_DIV_HIGH, got); chk(got, 16'h80);
        rd8(ADDR_DIV_LOW, got);  chk(got, 16'h02);
        wr8(ADDR_DIV_LOW, 8'h03);
        rd8(ADDR_DIV_LOW, got);  chk(got, 16'h03);
        wr8(ADDR_CONTROL, 8'h40);
        chk(arr_pd, 1);
        rd8(16'h0810, got); chk(got, RDATA_OFF);
        wr8(ADDR_CONTROL, 8'h00);
        $display("test reset_regs done");
    endtask

    task automatic test_latching();
        wr8(ADDR_CONTROL, 8'h08);
        wr8(16'h0100, 8'h77);
        chk(arr_addr, 16'h0000);
        wr8(ADDR_CONTROL, 8'h09);
        rd8(ADDR_CONTROL, got); chk(got, 16'h08);
        chk(arr_hv, 0);
        wr8(16'h0850, 8'h55);
        wr8(16'h0860, 8'hAA);
        chk(arr_addr, 16'h0860);
        chk(arr_data, 16'hAA);
        rd8(16'h0870, got); chk(got, 16'hAA);
        chk(arr_addr, 16'h0870);
        wr8(ADDR_DIV_LOW, 8'h10);
        rd8(ADDR_DIV_LOW, got); chk(got, 16'h03);
        wr8(ADDR_CONTROL, 8'h09);
        chk(arr_hv, 1);
        wr8(ADDR_CONTROL, 8'h00);
        rd8(ADDR_CONTROL, got); chk(got, 16'h08);
        chk(arr_hv, 0);
        wr8(ADDR_CONTROL, 8'h00);
        rd8(16'h0870, got); chk(got, 16'hAA);
        $display("test latching done");
    endtask

    task automatic test_auto_modes();
        logic [7:0] exp_rd [4];
        logic [15:0] rd_at [4];
        int n;
        exp_rd = '{8'h3C, 8'hFF, 8'hFF, 8'hFF};
        rd_at = '{16'h0810, 16'h0810, 16'h0870, 16'h0810};
        for (int m = 0; m < 4; m++) begin
            wr8(ADDR_CONTROL, 8'h0C | (m[1:0] << 4));
            wr8(16'h0810, 8'h3C);
            wr8(ADDR_CONTROL, 8'h0D | (m[1:0] << 4));
            // Bulk is refused while any block is protected
            chk(arr_hv, (m == 3) ? 16'h0 : 16'h1);
            chk(arr_mode, m[1:0]);
            n = 0;
            got = 8'h01;
            // Poll the control register only; array reads would spoil the cycle
            while (m != 3 && got[CTL_HV] !== 1'b0 && n < 200) begin
                rd8(ADDR_CONTROL, got);
                n++;
            end
            chk((n < 200) ? 16'h1 : 16'h0, 16'h1);
            chk(arr_hv, 0);
            wr8(ADDR_CONTROL, 8'h00);
            wr8(ADDR_CONTROL, 8'h00);
            rd8(rd_at[m], got); chk(got, exp_rd[m]);
        end
        wr8(ADDR_CONTROL, 8'h08);
        wr8(16'h0890, 8'h00);
        wr8(ADDR_CONTROL, 8'h09);
        chk(arr_hv, 0);
        wr8(ADDR_CONTROL, 8'h00);
        wr8(ADDR_CONTROL, 8'h00);
        $display("test auto_modes done");
    endtask

    task automatic test_security();
        logic [15:0] ta [3];
        logic [7:0]  tc [3];
        do_reset(8'hE0, 8'h05, 8'h02);
        rd8(ADDR_DIV_HIGH, got); chk(got, 16'h05);
        wr8(ADDR_DIV_LOW, 8'h09);
        rd8(ADDR_DIV_LOW, got); chk(got, 16'h02);
        wr8(ADDR_CONFIG, 8'hF0);
        rd8(ADDR_CONFIG, got); chk(got, 16'hE0);
        ta = '{16'h0810, 16'h08F5, 16'h0810};
        tc = '{8'h28, 8'h08, 8'h08};
        for (int k = 0; k < 3; k++) begin
            wr8(ADDR_CONTROL, tc[k]);
            wr8(ta[k], 8'hF0);
            wr8(ADDR_CONTROL, tc[k] | 8'h01);
            chk(arr_hv, (k == 2) ? 16'h1 : 16'h0);
            wr8(ADDR_CONTROL, 8'h00);
            wr8(ADDR_CONTROL, 8'h00);
        end
        $display("test security done");
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        nv_prot = 8'hF2;
        nv_divh = 8'h80;
        nv_divl = 8'h02;
        do_reset(8'hF2, 8'h80, 8'h02);
        test_reset_regs();
        test_latching();
        test_auto_modes();
        test_security();
        print_verdict();
    end
endmodule
